// File: logic/sss_cfg.svh
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH

// timing and limits
`define SSS_CLK_NS 10
`define SSS_MS_NS 1000000
`define SSS_PWRUP_MS 11'd1500
`define SSS_BCONT_MS 11'd1000
`define SSS_SUPPLY_MIN_V 10'd150
`define SSS_TL_MAX 9'd300

// register byte offsets
`define SSS_REG_IN_MAP 8'h00
`define SSS_REG_OUT_MAP 8'h04
`define SSS_REG_TLIM 8'h08
`define SSS_REG_ZSPD 8'h0C
`define SSS_REG_ZDEV 8'h10
`define SSS_REG_SETTLE 8'h14
`define SSS_REG_STATUS 8'h18
`define SSS_REG_CTRL 8'h1C

// terminal counts and field widths
`define SSS_N_IN 5
`define SSS_N_OUT 3
`define SSS_IN_CODE_W 5
`define SSS_OUT_CODE_W 4

// reset values
`define SSS_IN_MAP_RST 25'h00000C1
`define SSS_OUT_MAP_RST 12'h421
`define SSS_TLIM_RST 9'h12C
`define SSS_ZSPD_RST 16'h0064
`define SSS_ZDEV_RST 24'h000800
`define SSS_SETTLE_RST 10'h00A
`define SSS_CTRL_RST 2'h0

// input function codes
`define SSS_FN_SERVO_ON 5'h01
`define SSS_FN_FSTOP 5'h05
`define SSS_FN_ALM_RST 5'h06
`define SSS_FN_REGEN_OVH 5'h08
`define SSS_FN_OT_POS 5'h09
`define SSS_FN_OT_NEG 5'h0A
`define SSS_FN_TL_EN 5'h14
`define SSS_FN_COAST 5'h15

// output function codes
`define SSS_OF_READY 4'h1
`define SSS_OF_POSITION_SETTLED_OUT 4'h2
`define SSS_OF_ALM_A 4'h3
`define SSS_OF_ALM_B 4'h4
`define SSS_OF_DBRAKE 4'h5
`define SSS_OF_TL_HIT 4'hA

`endif

// File: logic/sss_pkg.sv
package sss_pkg;

  typedef enum logic [1:0] {
    SSS_MODE_POS = 2'b00,
    SSS_MODE_SPD = 2'b01,
    SSS_MODE_TRQ = 2'b10
  } sss_mode_e;

  typedef enum logic [1:0] {
    SSS_DRV_RUN = 2'b00,
    SSS_DRV_DECEL = 2'b01,
    SSS_DRV_BASEOFF = 2'b10
  } sss_drv_e;

  typedef struct packed {
    logic [9:0] torque_req;
    logic [15:0] speed_abs;
    logic [23:0] dev_abs;
    logic [9:0] supply_v;
  } sss_fbk_s;

  typedef struct packed {
    logic evt;
    logic minor;
    logic dbrake;
  } sss_alarm_s;

  typedef struct packed {
    logic drive_en;
    logic decel_max;
    logic [9:0] torque_out;
  } sss_cmd_s;

endpackage

// File: logic/sss_seq_status.sv
`timescale 1ns/1ns
`include "sss_cfg.svh"
module sss_seq_status #(
  parameter int MS_CYC = `SSS_MS_NS / `SSS_CLK_NS
) (
  input wire logic aclk, // 100 MHz
  input wire logic aresetn, // sync reset, active low
  input wire logic [`SSS_N_IN-1:0] seq_terminals_in, // host input pins
  input sss_pkg::sss_fbk_s fbk, // torque, speed, deviation, supply
  input sss_pkg::sss_alarm_s alarm, // alarm event with class
  output sss_pkg::sss_cmd_s cmd, // to drive stage
  output logic [`SSS_N_OUT-1:0] out_terminals, // host output pins
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  import sss_pkg::*;

  function automatic logic [1:0] in_fn(input logic [24:0] map,
                                       input logic [4:0] lvl,
                                       input logic [4:0] code);
    logic [1:0] r;
    r = 2'b00;
    for (int i = 0; i < `SSS_N_IN; i++) begin
      if (map[i*5 +: 5] == code) begin
        r = {1'b1, r[0] | lvl[i]};
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] wr_bytes(input logic [31:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // pin synchronisers: s1 feeds s2 only
  logic [`SSS_N_IN-1:0] sy1_q, sy2_q, sy3_q, pin_q;
  wire [`SSS_N_IN-1:0] pin_agree, pin_d;
  // a pin change counts once the last two stages agree
  assign pin_agree = ~(sy2_q ^ sy3_q);
  assign pin_d = (pin_agree & sy2_q) | (~pin_agree & pin_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_q <= '0;
      sy2_q <= '0;
      sy3_q <= '0;
      pin_q <= '0;
    end else begin
      sy1_q <= seq_terminals_in;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      pin_q <= pin_d;
    end
  end

  // registers
  logic [24:0] in_map_q;
  logic [11:0] out_map_q;
  logic [8:0] tlim_q;
  logic [15:0] zspd_q;
  logic [23:0] zdev_q;
  logic [9:0] settle_q;
  logic [1:0] mode_q;

  // function decode; unassigned reads as off, except torque limit enable, which reads as on
  wire [1:0] f_run, f_fstop, f_rst, f_regen, f_otp, f_otn, f_tl, f_coast;
  assign f_run = in_fn(in_map_q, pin_q, `SSS_FN_SERVO_ON);
  assign f_fstop = in_fn(in_map_q, pin_q, `SSS_FN_FSTOP);
  assign f_rst = in_fn(in_map_q, pin_q, `SSS_FN_ALM_RST);
  assign f_regen = in_fn(in_map_q, pin_q, `SSS_FN_REGEN_OVH);
  assign f_otp = in_fn(in_map_q, pin_q, `SSS_FN_OT_POS);
  assign f_otn = in_fn(in_map_q, pin_q, `SSS_FN_OT_NEG);
  assign f_tl = in_fn(in_map_q, pin_q, `SSS_FN_TL_EN);
  assign f_coast = in_fn(in_map_q, pin_q, `SSS_FN_COAST);

  wire servo_on, fstop, regen_ovh, overtravel, coast, tl_active;
  assign servo_on = f_run[0];
  assign fstop = f_fstop[0];
  assign regen_ovh = f_regen[0];
  assign overtravel = f_otp[0] | f_otn[0];
  assign coast = f_coast[0];
  assign tl_active = f_tl[1] ? f_tl[0] : 1'b1;

  // millisecond enable and power-up timer
  logic [16:0] div_q;
  logic [10:0] up_ms_q;
  wire ms_tick;
  assign ms_tick = (div_q == 17'(MS_CYC - 1));
  wire pwr_done, boot_done;
  assign pwr_done = (up_ms_q >= `SSS_PWRUP_MS);
  assign boot_done = (up_ms_q >= `SSS_BCONT_MS);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
      up_ms_q <= '0;
    end else begin
      div_q <= ms_tick ? 17'h00000 : div_q + 17'h00001;
      if (ms_tick && !pwr_done) begin
        up_ms_q <= up_ms_q + 11'h001;
      end
    end
  end

  // alarm latch, released by rising reset edge; new events win
  logic alm_q, minor_q, db_q, rst_prev_q;
  wire rst_rise;
  assign rst_rise = f_rst[0] & ~rst_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alm_q <= 1'b0;
      minor_q <= 1'b0;
      db_q <= 1'b0;
      rst_prev_q <= 1'b0;
    end else begin
      rst_prev_q <= f_rst[0];
      if (alarm.evt) begin
        alm_q <= 1'b1;
        // a latched major alarm is not downgraded by a later minor one
        minor_q <= alarm.minor & (minor_q | ~alm_q);
        db_q <= db_q | alarm.dbrake;
      end else if (rst_rise) begin
        alm_q <= 1'b0;
        minor_q <= 1'b0;
        db_q <= 1'b0;
      end
    end
  end

  wire major_now, zero_spd, zero_dev, stop_req;
  assign major_now = (alarm.evt & ~alarm.minor) | (alm_q & ~minor_q);
  assign zero_spd = (fbk.speed_abs <= zspd_q);
  // encoder pulses; 131072 per turn, only judged in position mode
  assign zero_dev = (mode_q != SSS_MODE_POS) ||
                    (fbk.dev_abs <= zdev_q);
  assign stop_req = ~servo_on | alm_q | alarm.evt;

  // drive sequencing
  sss_drv_e drv_q, drv_d;
  always_comb begin
    drv_d = drv_q;
    case (drv_q)
      SSS_DRV_RUN: begin
        if (major_now) begin
          drv_d = SSS_DRV_BASEOFF;
        end else if (stop_req) begin
          drv_d = SSS_DRV_DECEL;
        end
      end
      SSS_DRV_DECEL: begin
        if (major_now || zero_spd) begin
          drv_d = SSS_DRV_BASEOFF;
        end else if (!stop_req) begin
          drv_d = SSS_DRV_RUN;
        end
      end
      SSS_DRV_BASEOFF: begin
        if (!stop_req) begin
          drv_d = SSS_DRV_RUN;
        end
      end
      default: drv_d = SSS_DRV_BASEOFF;
    endcase
  end

  // clamp acts on requested torque regardless of control mode
  wire [9:0] tlim_w;
  wire tl_over, tl_hit;
  assign tlim_w = {1'b0, tlim_q};
  assign tl_over = tl_active && (fbk.torque_req > tlim_w);
  assign tl_hit = tl_active && (fbk.torque_req >= tlim_w);

  sss_cmd_s cmd_d;
  always_comb begin
    cmd_d.torque_out = tl_over ? tlim_w : fbk.torque_req;
    // coast overrides drive enable and max decel, not torque out; release resumes next cycle
    cmd_d.drive_en = ~coast & (drv_d != SSS_DRV_BASEOFF);
    cmd_d.decel_max = ~coast & ~major_now &
                      ((drv_d == SSS_DRV_DECEL) | fstop | overtravel);
  end

  // settling timer restarts on any dropout
  logic [9:0] settle_cnt_q;
  wire position_settled_out_cond, position_settled_out_d, ready_d;
  assign position_settled_out_cond = ~alm_q & ~alarm.evt & zero_spd & zero_dev & ~fstop &
                     pwr_done;
  assign position_settled_out_d = position_settled_out_cond && (settle_cnt_q >= settle_q);
  assign ready_d = servo_on & ~fstop & ~alm_q & ~alarm.evt & ~regen_ovh &
                   (fbk.supply_v > `SSS_SUPPLY_MIN_V) & ~coast;

  logic ready_q, position_settled_out_q, tl_hit_q, alm_b_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt_q <= '0;
      ready_q <= 1'b0;
      position_settled_out_q <= 1'b0;
      tl_hit_q <= 1'b0;
      alm_b_q <= 1'b0;
      drv_q <= SSS_DRV_BASEOFF;
      cmd <= '0;
    end else begin
      if (!position_settled_out_cond) begin
        settle_cnt_q <= '0;
      end else if (ms_tick && settle_cnt_q != 10'h3FF) begin
        settle_cnt_q <= settle_cnt_q + 10'h001;
      end
      ready_q <= ready_d;
      position_settled_out_q <= position_settled_out_d;
      tl_hit_q <= tl_hit;
      alm_b_q <= boot_done & ~alm_q;
      drv_q <= drv_d;
      cmd <= cmd_d;
    end
  end

  // output terminal routing
  logic [`SSS_N_OUT-1:0] out_d;
  always_comb begin
    for (int o = 0; o < `SSS_N_OUT; o++) begin
      case (out_map_q[o*4 +: 4])
        `SSS_OF_READY: out_d[o] = ready_q;
        `SSS_OF_POSITION_SETTLED_OUT: out_d[o] = position_settled_out_q;
        `SSS_OF_ALM_A: out_d[o] = alm_q;
        `SSS_OF_ALM_B: out_d[o] = alm_b_q;
        `SSS_OF_DBRAKE: out_d[o] = db_q;
        `SSS_OF_TL_HIT: out_d[o] = tl_hit_q;
        default: out_d[o] = 1'b0;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_terminals <= '0;
    end else begin
      out_terminals <= out_d;
    end
  end

  // bus slave: address and data taken in either order
  logic aw_got_q, w_got_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire wr_go;
  assign wr_go = aw_got_q & w_got_q & ~s_axi_bvalid;
  wire hit_in, hit_out, hit_tl, hit_zs, hit_zd, hit_st, hit_ctl, wr_ok;
  assign hit_in = (waddr_q == `SSS_REG_IN_MAP);
  assign hit_out = (waddr_q == `SSS_REG_OUT_MAP);
  assign hit_tl = (waddr_q == `SSS_REG_TLIM);
  assign hit_zs = (waddr_q == `SSS_REG_ZSPD);
  assign hit_zd = (waddr_q == `SSS_REG_ZDEV);
  assign hit_st = (waddr_q == `SSS_REG_SETTLE);
  assign hit_ctl = (waddr_q == `SSS_REG_CTRL);
  assign wr_ok = hit_in | hit_out | hit_tl | hit_zs | hit_zd | hit_st |
                 hit_ctl | (waddr_q == `SSS_REG_STATUS);
  wire [31:0] tl_new;
  assign tl_new = wr_bytes({23'h0, tlim_q}, wdata_q, wstrb_q);
  wire [31:0] in_new, out_new, zs_new, zd_new, st_new, ctl_new;
  assign in_new = wr_bytes({7'h0, in_map_q}, wdata_q, wstrb_q);
  assign out_new = wr_bytes({20'h0, out_map_q}, wdata_q, wstrb_q);
  assign zs_new = wr_bytes({16'h0, zspd_q}, wdata_q, wstrb_q);
  assign zd_new = wr_bytes({8'h0, zdev_q}, wdata_q, wstrb_q);
  assign st_new = wr_bytes({22'h0, settle_q}, wdata_q, wstrb_q);
  assign ctl_new = wr_bytes({30'h0, mode_q}, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      in_map_q <= `SSS_IN_MAP_RST;
      out_map_q <= `SSS_OUT_MAP_RST;
      tlim_q <= `SSS_TLIM_RST;
      zspd_q <= `SSS_ZSPD_RST;
      zdev_q <= `SSS_ZDEV_RST;
      settle_q <= `SSS_SETTLE_RST;
      mode_q <= `SSS_CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        s_axi_awready <= 1'b0;
        waddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
        if (hit_in) begin
          in_map_q <= in_new[24:0];
        end
        if (hit_out) begin
          out_map_q <= out_new[11:0];
        end
        if (hit_tl) begin
          // beyond 300 percent saturates
          tlim_q <= (tl_new > 32'(`SSS_TL_MAX)) ? `SSS_TL_MAX :
                    tl_new[8:0];
        end
        if (hit_zs) begin
          zspd_q <= zs_new[15:0];
        end
        if (hit_zd) begin
          zdev_q <= zd_new[23:0];
        end
        if (hit_st) begin
          settle_q <= st_new[9:0];
        end
        if (hit_ctl) begin
          mode_q <= ctl_new[1:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        // readies reopen only once the response is taken
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read path
  wire [31:0] status_w;
  assign status_w = {17'h0, drv_q, pin_q, pwr_done, cmd.decel_max,
                     cmd.drive_en, tl_hit_q, db_q, alm_q, position_settled_out_q, ready_q};
  wire [31:0] rd_w;
  wire rd_ok;
  assign rd_ok = (s_axi_araddr[7:5] == 3'h0) && (s_axi_araddr[1:0] == 2'h0);
  assign rd_w =
    (s_axi_araddr == `SSS_REG_IN_MAP) ? {7'h0, in_map_q} :
    (s_axi_araddr == `SSS_REG_OUT_MAP) ? {20'h0, out_map_q} :
    (s_axi_araddr == `SSS_REG_TLIM) ? {23'h0, tlim_q} :
    (s_axi_araddr == `SSS_REG_ZSPD) ? {16'h0, zspd_q} :
    (s_axi_araddr == `SSS_REG_ZDEV) ? {8'h0, zdev_q} :
    (s_axi_araddr == `SSS_REG_SETTLE) ? {22'h0, settle_q} :
    (s_axi_araddr == `SSS_REG_STATUS) ? status_w :
    (s_axi_araddr == `SSS_REG_CTRL) ? {30'h0, mode_q} : 32'h00000000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= rd_w;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_tl_clamp;
    tl_over |=> (cmd.torque_out == $past(tlim_w));
  endproperty
  a_tl_clamp: assert property (p_tl_clamp)
    else $error("torque not clamped to limit");

  property p_tl_hit;
    (tl_active && fbk.torque_req == tlim_w) |=> tl_hit_q;
  endproperty
  a_tl_hit: assert property (p_tl_hit)
    else $error("limit reached flag missing");

  property p_coast;
    coast |=> !cmd.drive_en && !cmd.decel_max;
  endproperty
  a_coast: assert property (p_coast)
    else $error("drive active during coast");

  property p_coast_release;
    ($fell(coast) && drv_d != SSS_DRV_BASEOFF) |=> cmd.drive_en;
  endproperty
  a_coast_release: assert property (p_coast_release)
    else $error("drive not resumed after coast release");

  property p_ready;
    ready_q |-> $past(servo_on && !coast && !fstop && !alm_q &&
                      fbk.supply_v > `SSS_SUPPLY_MIN_V);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready without its conditions");

  sequence s_drive_held_off;
    !cmd.drive_en ##1 !cmd.drive_en;
  endsequence
  property p_position_settled_out;
    $rose(position_settled_out_q) |-> $past(position_settled_out_cond) && !alm_q;
  endproperty
  a_position_settled_out: assert property (p_position_settled_out)
    else $error("complete without settled conditions");

  property p_pwrup;
    !$past(pwr_done) |-> !position_settled_out_q;
  endproperty
  a_pwrup: assert property (p_pwrup)
    else $error("complete before power-up time");

  property p_alarm_hold;
    (alm_q && !rst_rise) |=> alm_q && !position_settled_out_q;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold)
    else $error("alarm latch dropped without reset edge");

  property p_major;
    (alarm.evt && !alarm.minor && !coast) |=> s_drive_held_off;
  endproperty
  a_major: assert property (p_major)
    else $error("drive kept after major alarm");

  property p_bcont;
    !$past(boot_done) |-> !alm_b_q;
  endproperty
  a_bcont: assert property (p_bcont)
    else $error("inverted alarm active during boot");

  property p_db;
    (db_q && !alarm.evt && !rst_rise) |=> db_q;
  endproperty
  a_db: assert property (p_db)
    else $error("brake output released without reset");

  property p_settle_restart;
    !position_settled_out_cond |=> settle_cnt_q == 10'h000;
  endproperty
  a_settle_restart: assert property (p_settle_restart)
    else $error("settling count not restarted");

endmodule

// File: testbench/sss_host_model.sv
`timescale 1ns/1ns
module sss_host_model #(
  parameter int HOLD_CYC = 10100
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic servo_on, // run request
  input wire logic fstop, // forced stop request
  input wire logic coast, // coast request
  input wire logic tl_en, // torque limit enable
  input wire logic rst_req, // pulse: cause cleared, reset now
  input wire logic [2:0] out_terminals, // amplifier outputs
  output logic [4:0] seq_terminals_in, // amplifier inputs
  output logic alarm_seen // alarm as the host judges it
);
  logic [3:0] rst_cnt_q;
  logic [15:0] up_cnt_q;
  // reset pin held 8 cycles so it survives the input synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt_q <= 4'h0;
      up_cnt_q <= 16'h0;
    end else begin
      if (rst_req) begin
        rst_cnt_q <= 4'h8;
      end else if (rst_cnt_q != 4'h0) begin
        rst_cnt_q <= rst_cnt_q - 4'h1;
      end
      if (up_cnt_q < HOLD_CYC) begin
        up_cnt_q <= up_cnt_q + 16'h1;
      end
    end
  end
  assign seq_terminals_in = {tl_en, coast, rst_cnt_q != 4'h0, fstop,
                             servo_on};
  // low inverted alarm during power-up is not taken as an alarm
  assign alarm_seen = (up_cnt_q >= HOLD_CYC) && !out_terminals[2];
endmodule

// File: testbench/servo_sequence_status_logic_tb_top.sv
`timescale 1ns/1ns
`include "sss_cfg.svh"
`define CHK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); \
  end \
end
module servo_sequence_status_logic_tb_top;
  import sss_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, alarm_seen;
  logic servo_on, fstop, coast, tl_en, rst_req;
  logic [4:0] seq_terminals_in;
  logic [2:0] out_terminals;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  sss_fbk_s fbk;
  sss_alarm_s alarm;
  sss_cmd_s cmd;
  int fails, checks, n;

  sss_seq_status #(.MS_CYC(10)) sss_seq_status_i (.aclk(aclk),
    .aresetn(aresetn), .seq_terminals_in(seq_terminals_in), .fbk(fbk),
    .alarm(alarm), .cmd(cmd), .out_terminals(out_terminals),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  sss_host_model sss_host_model_i (.aclk(aclk), .aresetn(aresetn),
    .servo_on(servo_on), .fstop(fstop), .coast(coast), .tl_en(tl_en),
    .rst_req(rst_req), .out_terminals(out_terminals),
    .seq_terminals_in(seq_terminals_in), .alarm_seen(alarm_seen));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // handshakes judged at the falling edge, acted on at the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s = 4'hF);
    bit ta, tw, tb;
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) break;
    end
    bready <= 1'b0;
    if (k == 50) begin
      fails++;
      close_out();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    bit ta, tb;
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tb = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tb) break;
    end
    rready <= 1'b0;
    if (k == 50) begin
      fails++;
      close_out();
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e, input string nm);
    rd(a);
    `CHK(nm, e, d & m)
  endtask

  task automatic stat(input int b, input logic e, input string nm);
    rdchk(`SSS_REG_STATUS, 32'h1 << b, {31'h0, e} << b, nm);
  endtask

  task automatic hold(input int c);
    repeat (c) @(posedge aclk);
    @(negedge aclk);
  endtask

  initial begin
    aresetn = 1'b0;
    {servo_on, fstop, coast, tl_en, rst_req} = 5'h00;
    fbk = '0;
    alarm = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    fails = 0;
    checks = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(`SSS_REG_OUT_MAP, 32'hFFF, 32'h421, "out_map");
    rdchk(`SSS_REG_IN_MAP, 32'h1FFFFFF, `SSS_IN_MAP_RST, "in_map");
    // terminal 1 forced stop, terminal 2 alarm reset, 3 and 4 unused
    wr(`SSS_REG_IN_MAP, 32'h18A1);
    wr(`SSS_REG_TLIM, 32'h190);
    `CHK("wr_resp", 2'b00, r)
    rdchk(`SSS_REG_TLIM, 32'h1FF, 32'h12C, "tlim_sat");
    rd(8'h20);
    `CHK("unmapped_resp", 2'b10, r)
    wr(8'h20, 32'h1);
    `CHK("wr_unmapped", 2'b10, r)
    wr(`SSS_REG_ZSPD, 32'hFFFF_FF00, 4'h2);
    rdchk(`SSS_REG_ZSPD, 32'hFFFF, 32'hFF64, "zspd_strobe");
    wr(`SSS_REG_ZSPD, 32'h64);
    @(posedge aclk);
    fbk.supply_v <= 10'd200;
    fbk.torque_req <= 10'd350;
    servo_on <= 1'b1;
    hold(10);
    `CHK("ready_pin", 1'b1, out_terminals[0])
    `CHK("tl_unassigned", 10'd300, cmd.torque_out)
    stat(1, 1'b0, "early_complete");
    @(posedge aclk);
    fbk.supply_v <= 10'd150;
    hold(10);
    `CHK("ready_150v", 1'b0, out_terminals[0])
    @(posedge aclk);
    fbk.supply_v <= 10'd200;
    fstop <= 1'b1;
    hold(10);
    `CHK("ready_fstop", 1'b0, out_terminals[0])
    `CHK("fstop_decel", 1'b1, cmd.decel_max)
    @(posedge aclk);
    fstop <= 1'b0;
    wr(`SSS_REG_IN_MAP, 32'h014A98A1);
    wr(`SSS_REG_TLIM, 32'h32);
    @(posedge aclk);
    tl_en <= 1'b1;
    fbk.torque_req <= 10'd80;
    for (n = 0; n < 3; n++) begin
      wr(`SSS_REG_CTRL, n);
      hold(10);
      `CHK("tl_mode", 10'd50, cmd.torque_out)
      stat(4, 1'b1, "tl_hit");
    end
    @(posedge aclk);
    fbk.torque_req <= 10'd40;
    hold(5);
    stat(4, 1'b0, "tl_below");
    @(posedge aclk);
    tl_en <= 1'b0;
    fbk.torque_req <= 10'd80;
    hold(10);
    `CHK("tl_off", 10'd80, cmd.torque_out)
    wr(`SSS_REG_CTRL, 32'h1);
    @(posedge aclk);
    coast <= 1'b1;
    hold(10);
    `CHK("coast_drive", 1'b0, cmd.drive_en)
    `CHK("coast_ready", 1'b0, out_terminals[0])
    @(posedge aclk);
    coast <= 1'b0;
    hold(10);
    `CHK("coast_resume", 1'b1, cmd.drive_en)
    wr(`SSS_REG_CTRL, 32'h0);
    for (n = 0; n < 400; n++) begin
      hold(50);
      rd(`SSS_REG_STATUS);
      if (d[7]) break;
    end
    if (n == 400) begin
      fails++;
      close_out();
    end
    @(posedge aclk);
    fbk.dev_abs <= 24'd2048;
    hold(300);
    `CHK("complete", 1'b1, out_terminals[1])
    `CHK("alm_b_idle", 1'b1, out_terminals[2])
    @(posedge aclk);
    fbk.dev_abs <= 24'd2049;
    hold(5);
    `CHK("dev_out", 1'b0, out_terminals[1])
    @(posedge aclk);
    fbk.dev_abs <= 24'd0;
    hold(50);
    `CHK("settle_restart", 1'b0, out_terminals[1])
    hold(150);
    `CHK("settle_done", 1'b1, out_terminals[1])
    @(posedge aclk);
    alarm <= 3'b101;
    @(posedge aclk);
    alarm <= 3'b000;
    @(negedge aclk);
    `CHK("major_drive", 1'b0, cmd.drive_en)
    `CHK("major_decel", 1'b0, cmd.decel_max)
    hold(10);
    `CHK("alm_b_latched", 1'b0, out_terminals[2])
    `CHK("host_alarm", 1'b1, alarm_seen)
    stat(3, 1'b1, "dbrake");
    stat(1, 1'b0, "major_complete");
    wr(`SSS_REG_OUT_MAP, 32'hA53);
    hold(2);
    `CHK("out_codes", 3'b011, out_terminals)
    wr(`SSS_REG_OUT_MAP, 32'h421);
    @(posedge aclk);
    rst_req <= 1'b1;
    @(posedge aclk);
    rst_req <= 1'b0;
    hold(20);
    stat(3, 1'b0, "dbrake_clr");
    `CHK("alm_b_clr", 1'b1, out_terminals[2])
    @(posedge aclk);
    fbk.speed_abs <= 16'd500;
    alarm <= 3'b110;
    @(posedge aclk);
    alarm <= 3'b000;
    @(negedge aclk);
    `CHK("minor_decel", 1'b1, cmd.decel_max)
    `CHK("minor_drive", 1'b1, cmd.drive_en)
    @(posedge aclk);
    fbk.speed_abs <= 16'd0;
    hold(10);
    `CHK("minor_off", 1'b0, cmd.drive_en)
    stat(2, 1'b1, "minor_alarm");
    @(posedge aclk);
    rst_req <= 1'b1;
    @(posedge aclk);
    rst_req <= 1'b0;
    hold(300);
    `CHK("minor_back", 1'b1, out_terminals[1])
    // terminal 1 becomes positive overtravel
    wr(`SSS_REG_IN_MAP, 32'h014A9921);
    @(posedge aclk);
    fstop <= 1'b1;
    hold(10);
    `CHK("ot_decel", 1'b1, cmd.decel_max)
    `CHK("ot_complete", 1'b1, out_terminals[1])
    @(posedge aclk);
    fstop <= 1'b0;
    servo_on <= 1'b0;
    hold(300);
    `CHK("off_ready", 1'b0, out_terminals[0])
    `CHK("off_complete", 1'b1, out_terminals[1])
    close_out();
  end
endmodule
